// ===== design/acs_pkg.sv
package acs_pkg;

  // Register addresses carried in the address/control byte
  localparam logic [4:0] ADDR_DATA_TOP = 5'h0F;
  localparam logic [4:0] ADDR_MODE = 5'h10;
  localparam logic [4:0] ADDR_MASK = 5'h11;
  localparam logic [4:0] ADDR_SAR = 5'h12;
  localparam logic [4:0] ADDR_STAT = 5'h13;
  localparam logic [4:0] ADDR_STEP = 5'h01;
  localparam int ADDR_W = 5;

  // Conversion modes held in mode_q.mode
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_SCAN = 2'h2;
  localparam logic [1:0] MODE_CONT = 2'h3;

  // Sizes
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int RES_W = 10;
  localparam int LO_W = 8;
  localparam int BYTE_W = 8;

  // Reset and fill values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;
  localparam logic [3:0] HI_PAD = 4'h0;
  localparam logic [7:0] CH_ONE = 8'h01;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // Converter clock periods per channel conversion
  localparam int CONV_TICKS_DEF = 16;

  typedef enum logic [2:0] {
    CV_IDLE = 3'b001,
    CV_RUN = 3'b010,
    CV_GAP = 3'b100
  } acs_cv_state_t;

  typedef struct packed {
    logic osc;
    logic ce;
    logic sck;
    logic mosi;
  } acs_pins_t;

  typedef struct packed {
    logic rw;
    logic [1:0] spare;
    logic ctrl;
    logic [2:0] ch;
    logic half;
  } acs_addr_t;

  typedef struct packed {
    logic [1:0] spare;
    logic ext;
    logic vr;
    logic m8;
    logic ie;
    logic [1:0] mode;
  } acs_mode_t;

  typedef struct packed {
    logic convert_enable;
    logic [1:0] spare;
    logic load;
    logic [2:0] ch;
    logic half;
  } acs_sar_t;

  typedef struct packed {
    logic irq;
    logic all_done;
    logic busy;
    logic zero_hi;
    logic [2:0] ch;
    logic zero_lo;
  } acs_status_t;

  typedef struct packed {
    logic dv;
    logic dov;
    logic [1:0] msb;
    logic [7:0] lsb;
  } acs_result_t;

endpackage

// ===== design/acs_regs.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Hidden pointer names next channel to convert
// - Result reads advance pointer to next enabled
// - Pointer loaded by start write or address
// - Mask enables channels; disabled ones are skipped
// - Load bit high copies channel bits
// - Convert enable starts; clearing lets current finish
// - After loaded channel, ascend through enabled only
// - Start register reads back written channel bits
// - Half bit picks high/low in 10-bit
// - Ten-bit reads go high then low
// - Status stays selected until chip enable drops
// - Status bits 0 and 4 read zero
// - Interrupt flag sets like pin, clears on access
// - All-converted flag sets when every enabled done
// - Scan mode needs every enabled channel converted
// - Busy flag high per conversion, dips between
// - Busy may linger after stop until cleared
// - Status channel bits show live pointer
// - Start register bits 5, 6 ignored
// - Two mode bits: idle, single, scan, continuous
// - Results at 0-15, control at 16-19
module acs_regs #(
  parameter int CONV_TICKS = acs_pkg::CONV_TICKS_DEF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic spi_ce,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic osc_clk,
  input wire logic [acs_pkg::RES_W-1:0] conv_data,
  output logic [acs_pkg::CH_W-1:0] conv_channel,
  output logic conv_start,
  output logic irq_n_o,
  output logic irq_n_oe
);
  import acs_pkg::*;

  localparam int TICK_W = $clog2(CONV_TICKS + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CONV_TICKS - 1);
  localparam logic [TICK_W-1:0] TICK_ONE = TICK_W'(1);

  // Pin sampling
  acs_pins_t pin_lvl;
  acs_pins_t pin_rise;
  acs_pins_t pin_fall;

  acs_sync #(
    .W($bits(acs_pins_t))
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin({osc_clk, spi_ce, spi_sck, spi_mosi}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Serial framing state
  logic [2:0] bit_cnt;
  logic [BYTE_W-1:0] rx_sh;
  logic [BYTE_W-1:0] tx_sh;
  logic addr_phase;
  logic wr_mode;
  logic sel;
  logic [ADDR_W-1:0] cur_addr;

  // Register and sequencer state
  acs_mode_t mode_q;
  logic [NUM_CH-1:0] mask_q;
  acs_sar_t sar_q;
  logic convert_enable;
  logic [CH_W-1:0] ptr;
  logic half_lo;
  acs_cv_state_t state;
  logic [TICK_W-1:0] tick;
  logic converting_flag;
  logic irq_flag;
  logic acc_flag;
  logic irq_sent;
  acs_result_t res_mem [NUM_CH];
  logic [NUM_CH-1:0] dv_vec;

  function automatic logic [CH_W-1:0] next_enabled(
    input logic [CH_W-1:0] from,
    input logic [NUM_CH-1:0] en
  );
    logic [CH_W-1:0] cand;
    logic [CH_W-1:0] pick;
    logic found;
    pick = from;
    found = 1'b0;
    cand = from;
    for (int k = 1; k < NUM_CH; k++) begin
      cand = from + k[CH_W-1:0];
      if (!found && en[cand]) begin
        pick = cand;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  // Byte framing decode
  wire logic sck_rise = pin_rise.sck && pin_lvl.ce && sel;
  wire logic byte_done = sck_rise && (bit_cnt == BIT_LAST);
  wire logic [BYTE_W-1:0] rx_byte = {rx_sh[BYTE_W-2:0], pin_lvl.mosi};
  wire acs_addr_t addr_in = acs_addr_t'(rx_byte);
  wire acs_sar_t sar_in = acs_sar_t'(rx_byte);
  wire acs_mode_t mode_in = acs_mode_t'(rx_byte);
  wire logic addr_done = byte_done && addr_phase;
  wire logic data_done = byte_done && !addr_phase;
  wire logic in_data = cur_addr <= ADDR_DATA_TOP;
  wire logic ctrl_inc = (cur_addr >= ADDR_MODE) && (cur_addr < ADDR_STAT);

  // Access events, one ref_clk cycle each
  wire logic wr_ev = data_done && wr_mode;
  wire logic rd_ev = data_done && !wr_mode;
  wire logic mode_wr = wr_ev && (cur_addr == ADDR_MODE);
  wire logic mask_wr = wr_ev && (cur_addr == ADDR_MASK);
  wire logic sar_wr = wr_ev && (cur_addr == ADDR_SAR);
  wire logic res_rd = rd_ev && in_data;
  wire logic stat_rd = rd_ev && (cur_addr == ADDR_STAT);
  wire logic jam_rd = addr_done && !addr_in.ctrl;
  wire logic jam_sar = sar_wr && sar_in.load;
  wire logic chan_read_end = res_rd && (mode_q.m8 || half_lo);

  // Mode decode
  wire logic m_idle = mode_q.mode == MODE_IDLE;
  wire logic m_single = mode_q.mode == MODE_SINGLE;
  wire logic m_scan = mode_q.mode == MODE_SCAN;
  wire logic m_cont = mode_q.mode == MODE_CONT;
  wire logic abort = mode_wr && (mode_in.mode == MODE_IDLE);

  // Sequencing decode
  wire logic [NUM_CH-1:0] cur_hot = CH_ONE << conv_channel;
  wire logic [NUM_CH-1:0] done_vec = dv_vec | cur_hot;
  wire logic all_done_now = (mask_q != '0) && ((mask_q & ~done_vec) == '0);
  wire logic conv_done = (state == CV_RUN) && pin_rise.osc && (tick == TICK_LAST);
  wire logic finish_scan = m_scan && all_done_now;
  wire logic sar_go = sar_wr && sar_in.convert_enable && !m_idle;
  wire logic auto_go = chan_read_end && m_single && convert_enable;
  wire logic go = sar_go || auto_go;
  wire logic [CH_W-1:0] start_ch = jam_sar ? sar_in.ch : (auto_go ? rd_next : ptr);
  wire logic adv_conv = conv_done && (m_scan || m_cont);
  wire logic raise_irq = conv_done && (m_single || finish_scan);
  wire logic raise_acc = conv_done && all_done_now;
  wire logic [CH_W-1:0] rd_next = next_enabled(ptr, mask_q);
  wire logic [CH_W-1:0] cv_next = next_enabled(conv_channel, mask_q);
  wire logic [CH_W-1:0] hi8_next = next_enabled(addr_in.ch, mask_q);

  // Read data selection
  wire acs_result_t cur_res = res_mem[ptr];
  wire logic [BYTE_W-1:0] res_hi = {cur_res.dv, cur_res.dov, HI_PAD, cur_res.msb};
  wire logic [BYTE_W-1:0] res_byte = (mode_q.m8 || half_lo) ? cur_res.lsb : res_hi;
  wire acs_sar_t sar_view = '{
    convert_enable: convert_enable,
    spare: '0,
    load: sar_q.load,
    ch: sar_q.ch,
    half: half_lo
  };
  wire acs_status_t stat_view = '{
    irq: irq_flag,
    all_done: acc_flag,
    busy: converting_flag,
    zero_hi: 1'b0,
    ch: ptr,
    zero_lo: 1'b0
  };
  wire logic [BYTE_W-1:0] rd_value =
    in_data ? res_byte :
    (cur_addr == ADDR_MODE) ? mode_q :
    (cur_addr == ADDR_MASK) ? mask_q :
    (cur_addr == ADDR_SAR) ? sar_view :
    (cur_addr == ADDR_STAT) ? stat_view : RD_NONE;

  // Serial receive and address tracking
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bit_cnt <= BIT_FIRST;
      rx_sh <= REG_RST;
      addr_phase <= 1'b1;
      wr_mode <= 1'b0;
      sel <= 1'b0;
      cur_addr <= ADDR_STAT;
    end else if (pin_rise.ce) begin
      bit_cnt <= BIT_FIRST;
      addr_phase <= 1'b1;
      sel <= 1'b1;
    end else if (!pin_lvl.ce) begin
      sel <= 1'b0;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sh <= rx_byte;
      if (addr_done) begin
        addr_phase <= 1'b0;
        wr_mode <= addr_in.rw;
        cur_addr <= rx_byte[ADDR_W-1:0];
      end else if (byte_done && ctrl_inc) begin
        cur_addr <= cur_addr + ADDR_STEP;
      end
    end
  end

  // Serial transmit; new byte goes out on the falling edge ending a byte
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_sh <= REG_RST;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
      irq_sent <= 1'b0;
    end else begin
      spi_miso_oe <= sel && pin_lvl.ce && !addr_phase && !wr_mode;
      if (pin_fall.sck && sel) begin
        if (bit_cnt == BIT_FIRST) begin
          tx_sh <= rd_value;
          // Only an interrupt flag that went out may be cleared by the read
          irq_sent <= (cur_addr == ADDR_STAT) && irq_flag;
          spi_miso <= rd_value[BYTE_W-1];
        end else begin
          tx_sh <= {tx_sh[BYTE_W-2:0], 1'b0};
          spi_miso <= tx_sh[BYTE_W-2];
        end
      end
    end
  end

  // Writable registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_q <= acs_mode_t'(REG_RST);
      mask_q <= REG_RST;
      sar_q <= acs_sar_t'(REG_RST);
      convert_enable <= 1'b0;
    end else begin
      if (mode_wr) begin
        mode_q <= mode_in;
      end
      if (mask_wr) begin
        mask_q <= rx_byte;
      end
      if (sar_wr) begin
        convert_enable <= sar_in.convert_enable;
        sar_q.load <= sar_in.load;
        sar_q.ch <= sar_in.ch;
      end
    end
  end

  // Channel pointer and half select; host access outranks sequencer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ptr <= '0;
      half_lo <= 1'b0;
    end else if (jam_rd) begin
      // Address byte loads pointer; 8-bit mode with half clear takes next enabled channel
      if (mode_q.m8 && !addr_in.half) begin
        ptr <= hi8_next;
      end else begin
        ptr <= addr_in.ch;
      end
      half_lo <= addr_in.half || mode_q.m8;
    end else if (jam_sar) begin
      ptr <= sar_in.ch;
      half_lo <= sar_in.half;
    end else if (res_rd) begin
      if (chan_read_end) begin
        ptr <= rd_next;
        half_lo <= 1'b0;
      end else begin
        half_lo <= 1'b1;
      end
    end else if (adv_conv) begin
      ptr <= cv_next;
    end
  end

  // Conversion sequencer and status flags; sets follow clears so they win
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= CV_IDLE;
      tick <= '0;
      converting_flag <= 1'b0;
      irq_flag <= 1'b0;
      acc_flag <= 1'b0;
      conv_start <= 1'b0;
      conv_channel <= '0;
    end else begin
      conv_start <= 1'b0;
      if ((stat_rd && irq_sent) || res_rd || mode_wr || mask_wr) begin
        irq_flag <= 1'b0;
      end
      if (res_rd || mode_wr || mask_wr) begin
        acc_flag <= 1'b0;
      end
      if (res_rd || mode_wr || mask_wr || (sar_wr && (sar_in.convert_enable || sar_in.load))) begin
        converting_flag <= 1'b0;
      end
      if (raise_irq) begin
        irq_flag <= 1'b1;
      end
      if (raise_acc) begin
        acc_flag <= 1'b1;
      end
      case (state)
        CV_IDLE: begin
          if (go) begin
            state <= CV_RUN;
            tick <= '0;
            converting_flag <= 1'b1;
            conv_start <= 1'b1;
            conv_channel <= start_ch;
          end
        end
        CV_RUN: begin
          if (abort) begin
            state <= CV_IDLE;
            converting_flag <= 1'b0;
          end else if (conv_done) begin
            tick <= '0;
            if (m_single || finish_scan) begin
              state <= CV_IDLE;
              converting_flag <= 1'b0;
            end else if (convert_enable) begin
              state <= CV_GAP;
              converting_flag <= 1'b0;
            end else begin
              // Stopped scan leaves the busy flag as it stands
              state <= CV_IDLE;
            end
          end else if (pin_rise.osc) begin
            tick <= tick + TICK_ONE;
          end
        end
        CV_GAP: begin
          if (abort || !convert_enable || m_idle) begin
            state <= CV_IDLE;
          end else begin
            state <= CV_RUN;
            tick <= '0;
            converting_flag <= 1'b1;
            conv_start <= 1'b1;
            conv_channel <= ptr;
          end
        end
        default: begin
          state <= CV_IDLE;
        end
      endcase
    end
  end

  // Interrupt pin drives low only while enabled in modes 1 and 2
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_n_o <= 1'b0;
      irq_n_oe <= 1'b0;
    end else begin
      irq_n_o <= 1'b0;
      irq_n_oe <= mode_q.ie && irq_flag && (m_single || m_scan);
    end
  end

  // Per-channel result slots
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      acs_result_t slot;
      wire logic hit_cv = conv_done && (conv_channel == CH_W'(c));
      wire logic hit_rd = res_rd && (ptr == CH_W'(c));
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          slot <= '0;
        end else begin
          if (hit_rd || mode_wr || mask_wr) begin
            slot.dv <= 1'b0;
            slot.dov <= 1'b0;
          end
          if (hit_cv) begin
            slot.msb <= conv_data[RES_W-1:LO_W];
            slot.lsb <= conv_data[LO_W-1:0];
            slot.dv <= 1'b1;
            // Overrun only meaningful outside single scan
            slot.dov <= slot.dv && !m_scan;
          end
        end
      end
      assign res_mem[c] = slot;
      assign dv_vec[c] = slot.dv;
    end
  endgenerate

endmodule
`default_nettype wire

// ===== design/acs_sync.sv
`timescale 1ns/100ps
`default_nettype none
module acs_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire logic [W-1:0] agree = ~(s2 ^ s3);

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level <= '0;
      rise <= '0;
      fall <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= (level & ~agree) | (s3 & agree);
      rise <= agree & s3 & ~level;
      fall <= agree & ~s3 & level;
    end
  end
endmodule
`default_nettype wire

// ===== verification/acs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module acs_host_model (
  input wire logic ref_clk,
  input wire logic miso,
  output logic ce,
  output logic sck,
  output logic mosi
);
  initial begin
    ce = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
  end
  task automatic sel(input logic on);
    @(posedge ref_clk);
    ce <= on;
    repeat (8) @(posedge ref_clk);
  endtask
  // Mode 0, 8 clocks per sck period; miso sampled late in the high phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge ref_clk);
      mosi <= tx[i];
      repeat (3) @(posedge ref_clk);
      sck <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rx[i] = miso;
      sck <= 1'b0;
    end
    // Line not held after the byte
    @(posedge ref_clk);
    mosi <= ~mosi;
  endtask
endmodule
`default_nettype wire

// ===== verification/acs_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module acs_regs_monitor #(
  parameter int CONV_TICKS = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic spi_ce,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic osc_clk,
  input wire logic [acs_pkg::RES_W-1:0] conv_data,
  input wire logic [acs_pkg::CH_W-1:0] conv_channel,
  input wire logic conv_start,
  input wire logic irq_n_o,
  input wire logic irq_n_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too wide");
  a_conv_gap: assert property (conv_start |=> (!conv_start) [*3])
    else $error("conversion too short");
  a_chan_hold: assert property ($changed(conv_channel) && !$past(reset) |-> conv_start)
    else $error("channel moved without start");
  a_irq_level: assert property (irq_n_o == 1'b0)
    else $error("interrupt pin drives high");
  a_irq_not_start: assert property ($rose(irq_n_oe) |-> !conv_start)
    else $error("interrupt at conversion start");
  a_oe_idle: assert property ((!spi_ce) [*6] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  a_miso_quiet: assert property ((!spi_ce) [*6] |=> $stable(spi_miso))
    else $error("miso moves while deselected");
  a_oe_frame: assert property ($rose(spi_miso_oe) |-> $past(spi_ce, 8))
    else $error("miso driven before address byte");
  c_start: cover property (conv_start);
  c_irq: cover property ($rose(irq_n_oe));
  c_read: cover property ($rose(spi_miso_oe));
endmodule
bind acs_regs acs_regs_monitor #(.CONV_TICKS(CONV_TICKS)) mon (.ref_clk(ref_clk),
  .reset(reset), .spi_ce(spi_ce), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
  .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .osc_clk(osc_clk), .conv_data(conv_data),
  .conv_channel(conv_channel), .conv_start(conv_start), .irq_n_o(irq_n_o),
  .irq_n_oe(irq_n_oe));
`default_nettype wire

// ===== verification/acs_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module acs_regs_tb_top;
  import acs_pkg::*;
  localparam int TICKS = 3;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic osc_clk = 1'b0;
  logic spi_ce, spi_sck, spi_mosi, spi_miso, spi_miso_oe, conv_start, irq_n_oe, irq_n_o;
  logic [6:0] data_lo = 7'h2A;
  logic [RES_W-1:0] conv_data;
  logic [CH_W-1:0] conv_channel;
  logic [CH_W-1:0] seen[$];
  logic [CH_W-1:0] exp_ch[$] = '{3'h4, 3'h7, 3'h1, 3'h3, 3'h3, 3'h4};
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  always #50 osc_clk = ~osc_clk;
  // Channel number lands in d9..d7 so every result is traceable
  assign conv_data = {conv_channel, data_lo};
  acs_host_model host (.ref_clk(ref_clk), .miso(spi_miso), .ce(spi_ce), .sck(spi_sck),
    .mosi(spi_mosi));
  acs_regs #(.CONV_TICKS(TICKS)) dut (.ref_clk(ref_clk), .reset(reset), .spi_ce(spi_ce),
    .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .osc_clk(osc_clk), .conv_data(conv_data), .conv_channel(conv_channel),
    .conv_start(conv_start), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) seen.push_back(conv_channel);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d[$]);
    logic [7:0] r;
    host.sel(1'b1);
    host.xfer({3'b100, a}, r);
    foreach (d[i]) host.xfer(d[i], r);
    host.sel(1'b0);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e[$]);
    logic [7:0] r;
    host.sel(1'b1);
    host.xfer({3'b000, a}, r);
    foreach (e[i]) begin
      host.xfer(8'h00, r);
      chk(r & m, e[i]);
    end
    host.sel(1'b0);
  endtask
  // Poll status in one frame until a flag shows, then read once more
  task automatic poll(input logic [7:0] m, input logic [7:0] e, input logic [7:0] e2);
    logic [7:0] r;
    int n;
    n = 0;
    host.sel(1'b1);
    host.xfer({3'b000, ADDR_STAT}, r);
    r = 8'h00;
    while ((r & m) == 8'h00 && n < 100) begin
      host.xfer(8'h00, r);
      n++;
    end
    chk(r, e);
    host.xfer(8'h00, r);
    chk(r, e2);
    host.sel(1'b0);
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 400 && irq_n_oe !== 1'b1; i++) @(posedge ref_clk);
    chk({7'h00, irq_n_oe}, 8'h01);
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(ADDR_MODE, 8'hFF, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    wr(ADDR_MODE, '{{6'h00, MODE_SCAN}, 8'h92, 8'hF8});
    poll(8'h40, 8'hC8, 8'h48);
    rd(5'h08, 8'hFF, '{8'h82, 8'h2A, 8'h83, 8'hAA, 8'h80, 8'hAA, 8'h02});
    rd(ADDR_STAT, 8'hFF, '{8'h08});
    wr(ADDR_SAR, '{8'h04});
    rd(ADDR_STAT, 8'hFF, '{8'h08});
    wr(ADDR_SAR, '{8'h76});
    rd(ADDR_STAT, 8'hFF, '{8'h06});
    rd(ADDR_SAR, 8'h7E, '{8'h16});
    wr(ADDR_MODE, '{8'h05});
    wr(ADDR_SAR, '{8'h96});
    wait_irq();
    poll(8'h80, 8'h86, 8'h06);
    wr(ADDR_SAR, '{8'h96});
    wait_irq();
    rd(5'h06, 8'hFF, '{8'hC1, 8'hAA});
    wait_irq();
    wr(ADDR_MASK, '{8'h92});
    rd(ADDR_STAT, 8'hFF, '{8'h08});
    wr(ADDR_MODE, '{8'h00});
    chk({7'h00, irq_n_oe}, 8'h00);
    chk(8'(seen.size()), 8'(exp_ch.size()));
    foreach (exp_ch[i]) chk({5'h00, seen[i]}, {5'h00, exp_ch[i]});
    data_lo <= 7'h15;
    wr(ADDR_MODE, '{8'h0B});
    wr(ADDR_SAR, '{8'h98});
    repeat (150) @(posedge ref_clk);
    wr(ADDR_SAR, '{8'h00});
    wr(ADDR_SAR, '{8'h18});
    rd(ADDR_STAT, 8'hFF, '{8'h48});
    rd(5'h09, 8'hFF, '{8'h15, 8'h95, 8'h95});
    chk({7'h00, irq_n_o}, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
